// >>> verilog/disk_host_port_defines.svh
// constants shared by both ends of the disk controller host bus port
`ifndef DISK_HOST_PORT_DEFINES_SVH
`define DISK_HOST_PORT_DEFINES_SVH
`define IO_BASE         20'h00320
`define IO_PORT_DATA    2'h0
`define IO_PORT_CTRL    2'h1
`define IO_PORT_IRQCLR  2'h2
`define ROM_BASE        20'hC8000
`define SECTOR_BYTES    10'h200
`define CTRL_DMAEN      0
`define CTRL_DIR        1
`define CTRL_IRQEN      2
`define SETUP_CYC       4'h2
`define STROBE_CYC      4'hA
`define RECOVER_CYC     4'h2
`endif

// >>> verilog/disk_host_port_pkg.sv
// types shared by both ends of the disk controller host bus port
package disk_host_port_pkg;
    typedef enum logic [2:0] {OP_IO_RD, OP_IO_WR, OP_MEM_RD, OP_DMA_RD, OP_DMA_WR} host_op_e;
    // host pins as the controller samples them
    typedef struct packed {
        logic [19:0] addr;
        logic [7:0]  data;
        logic        aen;
        logic        memRdN;
        logic        ioRdN;
        logic        ioWrN;
        logic        dackN;
        logic        busRst;
    } pins_s;
endpackage

// >>> verilog/host_bus_if.sv
// host i/o channel wires between host end and controller end
`timescale 1ns/100ps
`default_nettype none
interface host_bus_if;
    logic [19:0] addr;
    logic        aen;
    logic        memRdN;
    logic        ioRdN;
    logic        ioWrN;
    logic        dackN;
    logic        busRst;
    logic [7:0]  hostData;
    logic        hostDataOe;
    logic [7:0]  devData;
    logic        devDataOe;
    logic        dmaReq;
    logic        intReq;
    modport device (input addr, aen, memRdN, ioRdN, ioWrN, dackN, busRst, hostData, hostDataOe,
                    output devData, devDataOe, dmaReq, intReq);
    modport host   (output addr, aen, memRdN, ioRdN, ioWrN, dackN, busRst, hostData, hostDataOe,
                    input devData, devDataOe, dmaReq, intReq);
endinterface
`default_nettype wire

// >>> verilog/disk_ctrl_host_port.sv
// controller end of the host bus port, with its inbound byte fifo
`timescale 1ns/100ps
`default_nettype none
`include "disk_host_port_defines.svh"

module byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic             mclk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] inData,
    input  wire logic             inValid,
    output logic                  inReady,
    output logic [WIDTH-1:0]      outData,
    output logic                  outValid,
    input  wire logic             outReady
);
    localparam int AW = $clog2(DEPTH);
    // refuse depths the wrapping pointers cannot serve
    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : gen_bad_params
        $error("byte_fifo: depth must be a power of two of at least 2");
    end
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wp;
        logic [AW-1:0]               rp;
        logic [AW:0]                 count;
    } fifo_s;
    fifo_s s_reg;
    fifo_s s_next;
    logic  push;
    logic  pop;

    always_comb begin
        s_next = s_reg;
        push   = inValid && (s_reg.count != DEPTH[AW:0]);
        pop    = outReady && (s_reg.count != '0);
        if (push) begin
            s_next.mem[s_reg.wp] = inData;
            s_next.wp            = s_reg.wp + 1'b1;
        end
        if (pop) begin
            s_next.rp = s_reg.rp + 1'b1;
        end
        s_next.count = s_reg.count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign inReady  = s_reg.count != DEPTH[AW:0];
    assign outValid = s_reg.count != '0;
    assign outData  = s_reg.mem[s_reg.rp];
endmodule

module disk_ctrl_host_port #(
    parameter int ROM_AW     = 13,
    parameter int FIFO_DEPTH = 16
) (
    input  wire logic      mclk,
    input  wire logic      rst_n,
    host_bus_if.device     bus,
    output logic [7:0]     rxData,
    output logic           rxValid,
    input  wire logic      rxReady,
    input  wire logic [7:0] txData,
    input  wire logic      txValid,
    output logic           txReady,
    output logic [ROM_AW-1:0] romAddr,
    input  wire logic [7:0] romData,
    input  wire logic      cmdDone,
    output logic           sectorDone
);
    import disk_host_port_pkg::*;
    if (ROM_AW < 8 || ROM_AW > 16) begin : gen_bad_rom_aw
        $error("disk_ctrl_host_port: rom address width out of range");
    end

    typedef struct packed {
        pins_s             sync1;
        pins_s             sync2;
        logic              ioRdPrev;
        logic              ioWrPrev;
        logic              memRdPrev;
        logic              rdWasData;
        logic              romPend;
        logic [7:0]        dataOut;
        logic              dataOe;
        logic [7:0]        outByte;
        logic              outFull;
        logic              pushValid;
        logic [7:0]        pushData;
        logic [2:0]        ctrl;
        logic              irqPend;
        logic              dmaReq;
        logic              intReq;
        logic [9:0]        byteCnt;
        logic              sectorDone;
        logic [ROM_AW-1:0] romAddr;
    } dev_s;

    dev_s  s_reg;
    dev_s  s_next;
    dev_s  rstVal;
    pins_s p;
    logic  fifoReady;
    logic  ioSel;
    logic  dataSel;
    logic  moved;

    function automatic logic ioHit(input logic [19:0] a);
        ioHit = (a >> 2) == (`IO_BASE >> 2);
    endfunction

    function automatic logic romHit(input logic [19:0] a);
        romHit = (a >> ROM_AW) == (`ROM_BASE >> ROM_AW);
    endfunction

    byte_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) byte_fifo_i (
        .mclk     (mclk),
        .rst_n    (rst_n && !s_reg.sync2.busRst),
        .inData   (s_reg.pushData),
        .inValid  (s_reg.pushValid),
        .inReady  (fifoReady),
        .outData  (rxData),
        .outValid (rxValid),
        .outReady (rxReady)
    );

    always_comb begin
        rstVal               = '0;
        p                    = s_reg.sync2;
        s_next               = s_reg;
        s_next.sync1         = {bus.addr, bus.hostData, bus.aen, bus.memRdN, bus.ioRdN,
                                bus.ioWrN, bus.dackN, bus.busRst};
        s_next.sync2         = s_reg.sync1;
        s_next.ioRdPrev      = !p.ioRdN;
        s_next.ioWrPrev      = !p.ioWrN;
        s_next.memRdPrev     = !p.memRdN;
        s_next.pushValid     = 1'b0;
        s_next.sectorDone    = 1'b0;
        s_next.romPend       = 1'b0;
        moved                = 1'b0;
        ioSel   = !p.aen && ioHit(p.addr);
        dataSel = (p.aen && !p.dackN) || (ioSel && p.addr[1:0] == `IO_PORT_DATA);
        // read strobe opens: drive data or status
        if (!p.ioRdN && !s_reg.ioRdPrev) begin
            if (dataSel) begin
                s_next.dataOut   = s_reg.outByte;
                s_next.dataOe    = 1'b1;
                s_next.rdWasData = 1'b1;
            end else if (ioSel) begin
                s_next.dataOut = {s_reg.irqPend, s_reg.dmaReq, s_reg.outFull, fifoReady,
                                  1'b0, s_reg.ctrl};
                s_next.dataOe  = 1'b1;
            end
        end
        if (p.ioRdN && s_reg.ioRdPrev) begin
            s_next.dataOe = 1'b0;
            if (s_reg.rdWasData) begin
                s_next.outFull   = 1'b0;
                s_next.rdWasData = 1'b0;
                moved            = 1'b1;
            end
        end
        // rom fetch takes one cycle to look up
        if (!p.memRdN && !s_reg.memRdPrev && !p.aen && romHit(p.addr)) begin
            s_next.romAddr = p.addr[ROM_AW-1:0];
            s_next.romPend = 1'b1;
        end
        if (s_reg.romPend) begin
            s_next.dataOut = romData;
            s_next.dataOe  = 1'b1;
        end
        if (p.memRdN && s_reg.memRdPrev) begin
            s_next.dataOe = 1'b0;
        end
        // write strobe opens: capture the byte
        if (!p.ioWrN && !s_reg.ioWrPrev) begin
            if (dataSel) begin
                s_next.pushData  = p.data;
                s_next.pushValid = fifoReady;
                moved            = fifoReady;
            end else if (ioSel && p.addr[1:0] == `IO_PORT_CTRL) begin
                s_next.ctrl = p.data[2:0];
            end else if (ioSel && p.addr[1:0] == `IO_PORT_IRQCLR) begin
                s_next.irqPend = 1'b0;
            end
        end
        if (cmdDone) begin
            s_next.irqPend = 1'b1;
        end
        if (txValid && !s_reg.outFull) begin
            s_next.outByte = txData;
            s_next.outFull = 1'b1;
        end
        if (moved) begin
            if (s_reg.byteCnt == `SECTOR_BYTES - 10'h001) begin
                s_next.byteCnt    = '0;
                s_next.sectorDone = 1'b1;
            end else begin
                s_next.byteCnt = s_reg.byteCnt + 10'h001;
            end
        end
        // request only while a byte can move and no i/o read or write strobe is in flight
        s_next.dmaReq = s_reg.ctrl[`CTRL_DMAEN] && p.ioRdN && p.ioWrN &&
                        (s_reg.ctrl[`CTRL_DIR] ? s_next.outFull && !s_reg.rdWasData
                                               : fifoReady);
        s_next.intReq = s_next.irqPend && s_reg.ctrl[`CTRL_IRQEN];
        // bus reset clears all but the synchronisers, which keep sampling so it can end
        if (p.busRst) begin
            rstVal.sync1 = s_next.sync1;
            rstVal.sync2 = s_next.sync2;
            s_next       = rstVal;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign bus.devData   = s_reg.dataOut;
    assign bus.devDataOe = s_reg.dataOe;
    assign bus.dmaReq    = s_reg.dmaReq;
    assign bus.intReq    = s_reg.intReq;
    assign txReady       = !s_reg.outFull;
    assign romAddr       = s_reg.romAddr;
    assign sectorDone    = s_reg.sectorDone;
endmodule
`default_nettype wire

// >>> verilog/host_bus_master.sv
// host end of the host bus port: runs i/o, rom and dma cycles
`timescale 1ns/100ps
`default_nettype none
`include "disk_host_port_defines.svh"

module host_bus_master (
    input  wire logic                     mclk,
    input  wire logic                     rst_n,
    host_bus_if.host                      bus,
    input  wire logic                     reqValid,
    input  wire disk_host_port_pkg::host_op_e reqOp,
    input  wire logic [19:0]              reqAddr,
    input  wire logic [7:0]               reqData,
    output logic                          reqReady,
    output logic                          rspValid,
    output logic [7:0]                    rspData,
    input  wire logic                     busReset,
    output logic                          dmaReqSeen,
    output logic                          intReqSeen
);
    import disk_host_port_pkg::*;
    typedef enum logic [1:0] {IDLE, SETUP, STROBE, RECOVER} state_e;
    typedef struct packed {
        state_e     st;
        logic [3:0] cnt;
        host_op_e   op;
        logic [19:0] addr;
        logic       aen;
        logic       memRdN;
        logic       ioRdN;
        logic       ioWrN;
        logic       dackN;
        logic       busRst;
        logic [7:0] hostData;
        logic       hostDataOe;
        logic [9:0] sync1;
        logic [9:0] sync2;
        logic       ready;
        logic       rspValid;
        logic [7:0] rspData;
    } host_s;
    host_s s_reg;
    host_s s_next;
    logic  isRead;

    always_comb begin
        s_next          = s_reg;
        s_next.sync1    = {bus.devData, bus.dmaReq, bus.intReq};
        s_next.sync2    = s_reg.sync1;
        s_next.rspValid = 1'b0;
        s_next.busRst   = busReset;
        isRead = s_reg.op == OP_IO_RD || s_reg.op == OP_MEM_RD || s_reg.op == OP_DMA_RD;
        case (s_reg.st)
            IDLE: begin
                if (reqValid && s_reg.ready) begin
                    s_next.op    = reqOp;
                    s_next.addr  = reqAddr;
                    s_next.aen   = reqOp == OP_DMA_RD || reqOp == OP_DMA_WR;
                    s_next.dackN = !(reqOp == OP_DMA_RD || reqOp == OP_DMA_WR);
                    s_next.hostData   = reqData;
                    s_next.hostDataOe = reqOp == OP_IO_WR || reqOp == OP_DMA_WR;
                    s_next.cnt   = `SETUP_CYC;
                    s_next.ready = 1'b0;
                    s_next.st    = SETUP;
                end
            end
            SETUP: begin
                s_next.cnt = s_reg.cnt - 4'h1;
                if (s_reg.cnt == 4'h1) begin
                    s_next.memRdN = s_reg.op != OP_MEM_RD;
                    s_next.ioRdN  = !(s_reg.op == OP_IO_RD || s_reg.op == OP_DMA_RD);
                    s_next.ioWrN  = !(s_reg.op == OP_IO_WR || s_reg.op == OP_DMA_WR);
                    s_next.cnt    = `STROBE_CYC;
                    s_next.st     = STROBE;
                end
            end
            STROBE: begin
                s_next.cnt = s_reg.cnt - 4'h1;
                if (s_reg.cnt == 4'h1) begin
                    s_next.rspData  = s_reg.sync2[9:2];
                    s_next.rspValid = isRead;
                    s_next.memRdN   = 1'b1;
                    s_next.ioRdN    = 1'b1;
                    s_next.ioWrN    = 1'b1;
                    s_next.cnt      = `RECOVER_CYC;
                    s_next.st       = RECOVER;
                end
            end
            RECOVER: begin
                s_next.cnt        = s_reg.cnt - 4'h1;
                s_next.hostDataOe = 1'b0;
                if (s_reg.cnt == 4'h1) begin
                    s_next.aen   = 1'b0;
                    s_next.dackN = 1'b1;
                    s_next.ready = 1'b1;
                    s_next.st    = IDLE;
                end
            end
            default: begin
                s_next.st = IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            s_reg        <= '0;
            s_reg.memRdN <= 1'b1;
            s_reg.ioRdN  <= 1'b1;
            s_reg.ioWrN  <= 1'b1;
            s_reg.dackN  <= 1'b1;
            s_reg.busRst <= 1'b1;
            s_reg.ready  <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    assign bus.addr       = s_reg.addr;
    assign bus.aen        = s_reg.aen;
    assign bus.memRdN     = s_reg.memRdN;
    assign bus.ioRdN      = s_reg.ioRdN;
    assign bus.ioWrN      = s_reg.ioWrN;
    assign bus.dackN      = s_reg.dackN;
    assign bus.busRst     = s_reg.busRst;
    assign bus.hostData   = s_reg.hostData;
    assign bus.hostDataOe = s_reg.hostDataOe;
    assign reqReady       = s_reg.ready;
    assign rspValid       = s_reg.rspValid;
    assign rspData        = s_reg.rspData;
    assign dmaReqSeen     = s_reg.sync2[1];
    assign intReqSeen     = s_reg.sync2[0];
endmodule
`default_nettype wire

// >>> verif/disk_ctrl_host_bus_port_assertions.sv
// concurrent checks on the host bus wires between host end and controller end
`timescale 1ns/100ps
`default_nettype none
`include "disk_host_port_defines.svh"
module disk_ctrl_host_bus_port_assertions #(
    parameter int ROM_AW = 13
) (
    input wire logic        mclk,
    input wire logic        rst_n,
    input wire logic [19:0] addr,
    input wire logic        aen,
    input wire logic        memRdN,
    input wire logic        ioRdN,
    input wire logic        ioWrN,
    input wire logic        dackN,
    input wire logic        busRst,
    input wire logic [7:0]  hostData,
    input wire logic        hostDataOe,
    input wire logic [7:0]  devData,
    input wire logic        devDataOe,
    input wire logic        dmaReq,
    input wire logic        intReq
);
    logic inRom;
    assign inRom = (addr >= `ROM_BASE) && (addr < `ROM_BASE + (20'h1 << ROM_AW));

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    sequence statusRdStart;
        $fell(ioRdN) && !aen && (addr == `IO_BASE + 20'h1);
    endsequence
    sequence romRdStart;
        $fell(memRdN) && !aen && inRom;
    endsequence
    sequence dmaRdStart;
        $fell(ioRdN) && aen && !dackN;
    endsequence

    status_read_drive_a: assert property (statusRdStart |-> ##[1:6] devDataOe)
        else $error("status read not answered");
    rom_read_drive_a: assert property (romRdStart |-> ##[1:8] devDataOe)
        else $error("rom read not answered");
    dma_read_select_a: assert property (dmaRdStart |-> ##[1:6] devDataOe)
        else $error("dma read not answered");
    drive_needs_read_a: assert property ($rose(devDataOe) |-> (!ioRdN || !memRdN))
        else $error("data driven without read strobe");
    dma_drive_ack_a: assert property ($rose(devDataOe) && aen |-> !dackN)
        else $error("data driven under aen without ack");
    bus_no_clash_a: assert property (!(devDataOe && hostDataOe))
        else $error("both ends drive data bus");
    read_hold_a: assert property ($rose(devDataOe) |-> devDataOe [*6])
        else $error("read data released early");
    write_addr_hold_a: assert property ($fell(ioWrN) |-> $stable(addr) [*8])
        else $error("address moved during write strobe");
    dack_with_aen_a: assert property ($fell(dackN) |-> aen)
        else $error("ack without aen");
    bus_reset_quiet_a: assert property (busRst [*3] |-> ##2 (!devDataOe && !dmaReq && !intReq))
        else $error("outputs active in bus reset");
endmodule
`default_nettype wire

// >>> verif/disk_ctrl_host_bus_port_tb.sv
// self-checking bench joining host end and controller end
`timescale 1ns/100ps
`default_nettype none
`include "disk_host_port_defines.svh"
module disk_ctrl_host_bus_port_tb;
    import disk_host_port_pkg::*;
    logic        mclk = 1'b0;
    logic        rst_n = 1'b0;
    logic        reqValid = 1'b0;
    host_op_e    reqOp = OP_IO_RD;
    logic [19:0] reqAddr = 20'h00000;
    logic [7:0]  reqData = 8'h00;
    logic        busReset = 1'b0;
    logic        rxReady = 1'b0;
    logic [7:0]  txData = 8'h00;
    logic        txValid = 1'b0;
    logic        cmdDone = 1'b0;
    logic [7:0]  romData;
    logic [12:0] romAddr;
    logic [7:0]  rxData;
    logic [7:0]  rspData;
    logic        rxValid, txReady, sectorDone, reqReady, rspValid, dmaReqSeen, intReqSeen;
    int          mismatches = 0;
    int          cmpCount = 0;
    int          oeCnt = 0;
    int          secCnt = 0;
    logic [7:0]  r;
    logic [7:0]  q[$];
    logic [19:0] offA[4] = '{20'hCA000, 20'hC7FFF, 20'h10321, 20'h00324};

    host_bus_if bus();
    always #5 mclk = ~mclk;
    // rom contents: low address byte with a fixed pattern
    assign romData = romAddr[7:0] ^ 8'h5C;
    always @(posedge mclk) begin
        if (bus.devDataOe === 1'b1) oeCnt <= oeCnt + 1;
        if (sectorDone === 1'b1) secCnt <= secCnt + 1;
    end

    disk_ctrl_host_port #(.ROM_AW(13), .FIFO_DEPTH(16)) disk_ctrl_host_port_i (
        .mclk(mclk), .rst_n(rst_n), .bus(bus.device), .rxData(rxData), .rxValid(rxValid),
        .rxReady(rxReady), .txData(txData), .txValid(txValid), .txReady(txReady),
        .romAddr(romAddr), .romData(romData), .cmdDone(cmdDone), .sectorDone(sectorDone));
    host_bus_master host_bus_master_i (
        .mclk(mclk), .rst_n(rst_n), .bus(bus.host), .reqValid(reqValid), .reqOp(reqOp),
        .reqAddr(reqAddr), .reqData(reqData), .reqReady(reqReady), .rspValid(rspValid),
        .rspData(rspData), .busReset(busReset), .dmaReqSeen(dmaReqSeen), .intReqSeen(intReqSeen));
    disk_ctrl_host_bus_port_assertions #(.ROM_AW(13)) disk_ctrl_host_bus_port_assertions_i (
        .mclk(mclk), .rst_n(rst_n), .addr(bus.addr), .aen(bus.aen), .memRdN(bus.memRdN),
        .ioRdN(bus.ioRdN), .ioWrN(bus.ioWrN), .dackN(bus.dackN), .busRst(bus.busRst),
        .hostData(bus.hostData), .hostDataOe(bus.hostDataOe), .devData(bus.devData),
        .devDataOe(bus.devDataOe), .dmaReq(bus.dmaReq), .intReq(bus.intReq));

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        cmpCount++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic endSim();
        if (mismatches == 0 && cmpCount > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    // one host cycle; spacing afterwards lets the controller release the bus
    task automatic hostOp(input host_op_e op, input logic [19:0] a, input logic [7:0] d,
                          output logic [7:0] rd);
        int   n;
        logic isRd;
        n = 0;
        isRd = op == OP_IO_RD || op == OP_MEM_RD || op == OP_DMA_RD;
        reqValid <= 1'b1;
        reqOp <= op;
        reqAddr <= a;
        reqData <= d;
        do @(posedge mclk); while (reqReady !== 1'b1);
        reqValid <= 1'b0;
        // reads end on the response pulse, writes when the host end is ready again
        do begin @(posedge mclk); n++; end
        while ((isRd ? rspValid : reqReady) !== 1'b1 && n < 200);
        rd = rspData;
        check({7'h00, isRd ? rspValid : reqReady}, 8'h01);
        repeat (4) @(posedge mclk);
    endtask

    task automatic txLoad(input logic [7:0] d);
        int n;
        n = 0;
        txData <= d;
        txValid <= 1'b1;
        do begin @(posedge mclk); n++; end while (txReady !== 1'b1 && n < 50);
        check({7'h00, txReady}, 8'h01);
        txValid <= 1'b0;
        repeat (4) @(posedge mclk);
    endtask

    task automatic drain();
        int k;
        k = 0;
        rxReady <= 1'b1;
        while (q.size() > 0 && k < 400) begin
            @(posedge mclk);
            k++;
            if (rxValid === 1'b1) check(rxData, q.pop_front());
        end
        check(8'(q.size()), 8'h00);
        rxReady <= 1'b0;
    endtask

    initial begin
        int n;
        repeat (5) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (2) @(posedge mclk);
        check({5'h00, bus.devDataOe, bus.dmaReq, bus.intReq}, 8'h00);
        hostOp(OP_IO_RD, `IO_BASE + 20'h1, 8'h00, r); check(r, 8'h10);
        hostOp(OP_MEM_RD, `ROM_BASE + 20'h01234, 8'h00, r); check(r, 8'h34 ^ 8'h5C);
        hostOp(OP_MEM_RD, `ROM_BASE + 20'h01FFF, 8'h00, r); check(r, 8'hFF ^ 8'h5C);
        for (int i = 0; i < 4; i++) begin
            n = oeCnt;
            hostOp((i < 2) ? OP_MEM_RD : OP_IO_RD, offA[i], 8'h00, r);
            check(8'(oeCnt - n), 8'h00);
        end
        // fill the inbound fifo with the far side stalled, one write too many
        for (int i = 0; i < 16; i++) begin
            hostOp(OP_IO_WR, `IO_BASE, 8'(i), r);
            q.push_back(8'(i));
        end
        hostOp(OP_IO_RD, `IO_BASE + 20'h1, 8'h00, r); check(r, 8'h00);
        hostOp(OP_IO_WR, `IO_BASE, 8'hEE, r);
        drain();
        hostOp(OP_IO_RD, `IO_BASE + 20'h1, 8'h00, r); check(r, 8'h10);
        txLoad(8'hA7);
        hostOp(OP_IO_RD, `IO_BASE + 20'h1, 8'h00, r); check(r, 8'h30);
        hostOp(OP_IO_RD, `IO_BASE, 8'h00, r); check(r, 8'hA7);
        hostOp(OP_IO_RD, `IO_BASE + 20'h1, 8'h00, r); check(r, 8'h10);
        // dma into the controller, address lines point at status
        hostOp(OP_IO_WR, `IO_BASE + 20'h1, 8'h01, r);
        repeat (6) @(posedge mclk);
        check({7'h00, bus.dmaReq}, 8'h01);
        check({7'h00, dmaReqSeen}, 8'h01);
        hostOp(OP_DMA_WR, `IO_BASE + 20'h1, 8'h5A, r);
        q.push_back(8'h5A);
        drain();
        hostOp(OP_IO_WR, `IO_BASE + 20'h1, 8'h03, r);
        repeat (6) @(posedge mclk);
        check({7'h00, bus.dmaReq}, 8'h00);
        txLoad(8'hC3);
        repeat (6) @(posedge mclk);
        check({7'h00, bus.dmaReq}, 8'h01);
        hostOp(OP_DMA_RD, `IO_BASE + 20'h1, 8'h00, r); check(r, 8'hC3);
        repeat (6) @(posedge mclk);
        check({7'h00, bus.dmaReq}, 8'h00);
        hostOp(OP_IO_WR, `IO_BASE + 20'h1, 8'h04, r);
        cmdDone <= 1'b1;
        @(posedge mclk);
        cmdDone <= 1'b0;
        repeat (8) @(posedge mclk);
        check({7'h00, intReqSeen}, 8'h01);
        hostOp(OP_IO_RD, `IO_BASE + 20'h1, 8'h00, r); check(r, 8'h94);
        hostOp(OP_IO_WR, `IO_BASE + 20'h2, 8'h00, r);
        repeat (8) @(posedge mclk);
        check({7'h00, bus.intReq}, 8'h00);
        busReset <= 1'b1;
        repeat (6) @(posedge mclk);
        busReset <= 1'b0;
        repeat (8) @(posedge mclk);
        hostOp(OP_IO_RD, `IO_BASE + 20'h1, 8'h00, r); check(r, 8'h10);
        rxReady <= 1'b1;
        n = secCnt;
        for (int i = 0; i < 511; i++) hostOp(OP_IO_WR, `IO_BASE, 8'(i), r);
        check(8'(secCnt - n), 8'h00);
        hostOp(OP_IO_WR, `IO_BASE, 8'hFF, r);
        check(8'(secCnt - n), 8'h01);
        endSim();
    end

    initial begin
        repeat (40000) @(posedge mclk);
        mismatches++;
        endSim();
    end
endmodule
`default_nettype wire
